// ### rtl/fcer_consts.vh
`ifndef FCER_CONSTS_VH
`define FCER_CONSTS_VH
`define FCER_OP_FORMAT 8'h04
`define FCER_OP_CHECK 8'h05
`define FCER_E_NONE 6'h00
`define FCER_E_NO_INDEX 6'h01
`define FCER_E_NO_SEEK 6'h02
`define FCER_E_WFAULT 6'h03
`define FCER_E_NOT_READY 6'h04
`define FCER_E_TRK0 6'h06
`define FCER_E_SEEKING 6'h08
`define FCER_E_HDR 6'h10
`define FCER_E_UNCORR 6'h11
`define FCER_E_NO_MARK 6'h12
`define FCER_E_NOT_FOUND 6'h14
`define FCER_E_SEEK_ERR 6'h15
`define FCER_E_CORR 6'h18
`define FCER_E_BAD_TRK 6'h19
`define FCER_E_FORMAT 6'h1a
`define FCER_E_SUB_DIRECT 6'h1c
`define FCER_E_SUB_USED 6'h1d
`define FCER_E_SUB_NOFLAG 6'h1e
`define FCER_E_SUB_SAME 6'h1f
`define FCER_E_BAD_CMD 6'h20
`define FCER_E_BAD_ADDR 6'h21
`define FCER_E_BAD_PARAM 6'h22
`define FCER_E_RAM 6'h30
`define FCER_E_CHKSUM 6'h31
`define FCER_E_ECC 6'h32
`define FCER_FILL 8'h6c
`define FCER_CB_RETRY_OFF 7
`define FCER_CB_PATTERN 5
`define FCER_CB_SERVO 4
`define FCER_IL_MAX_256 5'd31
`define FCER_IL_MAX_512 5'd16
`define FCER_SERVO_US 300
`define FCER_CLK_MHZ 100
`define FCER_SERVO_CYC (`FCER_SERVO_US * `FCER_CLK_MHZ)
`endif

// ### rtl/fcer_il_table.v
`include "fcer_consts.vh"
`default_nettype none
// builds interleave table: physical slot -> logical sector
module fcer_il_table #(
  parameter SW = 5
) (
  input wire clk_sys,
  input wire nrst,
  input wire start,
  input wire [SW-1:0] nsec,
  input wire [4:0] ilv,
  input wire [SW-1:0] rd_idx,
  output reg [SW-1:0] rd_val,
  output reg done
);
  reg [SW-1:0] tab [0:(1<<SW)-1];
  reg [(1<<SW)-1:0] used_ff;
  reg [SW-1:0] pos_ff;
  reg [SW-1:0] log_ff;
  reg busy_ff;
  reg [SW:0] sum;
  reg [SW-1:0] wpos;

  // next physical slot: step by interleave, wrap at nsec; used slots are skipped in the fill block
  always @*
  begin
    sum = {1'b0, pos_ff} + {{(SW-4){1'b0}}, ilv};
    if (sum >= {1'b0, nsec})
      sum = sum - {1'b0, nsec};
    wpos = sum[SW-1:0];
  end

  // fill at most one table entry per clock; a used slot costs a clock
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      used_ff <= {(1<<SW){1'b0}};
      pos_ff <= {SW{1'b0}};
      log_ff <= {SW{1'b0}};
      busy_ff <= 1'b0;
      done <= 1'b0;
    end
    else if (start)
    begin
      used_ff <= {(1<<SW){1'b0}};
      pos_ff <= {SW{1'b0}};
      log_ff <= {SW{1'b0}};
      busy_ff <= 1'b1;
      done <= 1'b0;
    end
    else if (busy_ff)
    begin
      if (used_ff[pos_ff])
        pos_ff <= (pos_ff + 1'b1 >= nsec) ? {SW{1'b0}} : pos_ff + 1'b1;
      else
      begin
        used_ff[pos_ff] <= 1'b1;
        log_ff <= log_ff + 1'b1;
        pos_ff <= wpos;
        if (log_ff + 1'b1 == nsec)
        begin
          busy_ff <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  // table storage and read port
  always @(posedge clk_sys)
  begin
    if (busy_ff && !used_ff[pos_ff])
      tab[pos_ff] <= log_ff;
    rd_val <= tab[rd_idx];
  end
endmodule // fcer_il_table
`default_nettype wire

// ### rtl/fcer_top.v
`include "fcer_consts.vh"
`default_nettype none
// format drive / check track sequencer with sense reporting
module fcer_top #(
  parameter SW = 5,
  parameter MAX_LBA = 21'h1fffff
) (
  input wire clk_sys,
  input wire nrst,
  input wire cmd_valid,
  input wire [7:0] cmd_op,
  input wire [20:0] cmd_lba,
  input wire [7:0] cmd_b4,
  input wire [7:0] cmd_ctl,
  input wire sec512,
  input wire [SW-1:0] nsec,
  input wire [20:0] sec_per_trk_lba,
  input wire drv_op_done,
  input wire [5:0] drv_err,
  input wire [31:0] rot_cycles,
  input wire [SW-1:0] hdr_sec,
  input wire hdr_bad,
  input wire hdr_sub_flag,
  input wire sub_via_defect,
  input wire diag_done,
  input wire [5:0] diag_err,
  input wire asg_valid,
  input wire [20:0] asg_def,
  input wire [20:0] asg_sub,
  input wire asg_sub_used,
  input wire asg_sub_noflag,
  output reg [2:0] drv_op,
  output reg drv_op_go,
  output reg [SW-1:0] drv_sec,
  output reg [7:0] fill_byte,
  output reg fill_keep,
  output reg [31:0] sec_slot_cycles,
  output reg [3:0] step_rate,
  output reg retry_off,
  output reg busy,
  output reg cmd_done,
  output reg [7:0] sense0,
  output reg [20:0] sense_lba
);
  localparam OP_RECAL = 3'd1;
  localparam OP_SEEK = 3'd2;
  localparam OP_TIME = 3'd3;
  localparam OP_WHDR = 3'd4;
  localparam OP_RHDR = 3'd5;
  localparam OP_WDATA = 3'd6;
  localparam S_IDLE = 4'd0;
  localparam S_TAB = 4'd1;
  localparam S_RECAL = 4'd2;
  localparam S_SEEK = 4'd3;
  localparam S_TIME = 4'd4;
  localparam S_WHDR = 4'd5;
  localparam S_RHDR = 4'd6;
  localparam S_WDATA = 4'd7;
  localparam S_END = 4'd8;
  localparam S_WAIT = 4'd9;

  reg [3:0] st_ff;
  reg [3:0] nxt_st;
  reg is_fmt_ff;
  reg [SW-1:0] sec_ff;
  reg [20:0] trk_lba_ff;
  reg [4:0] ilv_ff;
  reg tab_start_ff;
  wire [SW-1:0] tab_val;
  wire tab_done;
  reg [5:0] code;
  reg [31:0] slot_base;

  fcer_il_table #(.SW(SW)) u_tab (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(tab_start_ff),
    .nsec(nsec),
    .ilv(ilv_ff),
    .rd_idx(sec_ff),
    .rd_val(tab_val),
    .done(tab_done)
  );

  // class of error code sits in bits 5-4, code in 3-0
  // only documented codes are ever loaded here
  function [5:0] legal;
    input [5:0] c;
    begin
      case (c)
        6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08: legal = c;
        6'h10, 6'h11, 6'h12, 6'h14, 6'h15, 6'h18, 6'h19: legal = c;
        6'h1a, 6'h1c, 6'h1d, 6'h1e, 6'h1f: legal = c;
        6'h20, 6'h21, 6'h22: legal = c;
        6'h30, 6'h31, 6'h32: legal = c;
        default: legal = `FCER_E_NONE;
      endcase
    end
  endfunction

  // parameter check on a new command
  always @*
  begin
    code = `FCER_E_NONE;
    if (cmd_op != `FCER_OP_FORMAT && cmd_op != `FCER_OP_CHECK)
      code = `FCER_E_BAD_CMD;
    else if (cmd_lba > MAX_LBA)
      code = `FCER_E_BAD_ADDR;
    else if (cmd_b4[4:0] == 5'd0 ||
             cmd_b4[4:0] > (sec512 ? `FCER_IL_MAX_512 : `FCER_IL_MAX_256))
      code = `FCER_E_BAD_PARAM;
  end

  // servo gap trims the measured rotation time
  always @*
  begin
    if (cmd_ctl[`FCER_CB_SERVO] && rot_cycles > `FCER_SERVO_CYC)
      slot_base = rot_cycles - `FCER_SERVO_CYC;
    else
      slot_base = rot_cycles;
  end

  // next state
  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: nxt_st = st_ff;
      // done from the previous build still stands while start is in flight
      S_TAB: if (tab_done && !tab_start_ff) nxt_st = is_fmt_ff ? S_RECAL : S_SEEK;
      S_RECAL: if (drv_op_done) nxt_st = S_SEEK;
      S_SEEK: if (drv_op_done) nxt_st = is_fmt_ff ? S_TIME : S_RHDR;
      S_TIME: if (drv_op_done) nxt_st = S_WHDR;
      S_WHDR: if (drv_op_done && sec_ff + 1'b1 == nsec) nxt_st = S_RHDR;
      S_RHDR: if (drv_op_done && sec_ff + 1'b1 == nsec)
                nxt_st = is_fmt_ff ? S_WDATA : S_END;
      S_WDATA: if (drv_op_done && sec_ff + 1'b1 == nsec) nxt_st = S_END;
      S_END: nxt_st = S_IDLE;
      S_WAIT: nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end

  // sequencer, drive requests and sense reporting
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= S_IDLE;
      is_fmt_ff <= 1'b0;
      sec_ff <= {SW{1'b0}};
      trk_lba_ff <= 21'h0;
      ilv_ff <= 5'd1;
      tab_start_ff <= 1'b0;
      drv_op <= 3'd0;
      drv_op_go <= 1'b0;
      drv_sec <= {SW{1'b0}};
      fill_byte <= `FCER_FILL;
      fill_keep <= 1'b0;
      sec_slot_cycles <= 32'h0;
      step_rate <= 4'h0;
      retry_off <= 1'b0;
      busy <= 1'b0;
      cmd_done <= 1'b0;
      sense0 <= 8'h00;
      sense_lba <= 21'h0;
    end
    else
    begin
      drv_op_go <= 1'b0;
      tab_start_ff <= 1'b0;
      cmd_done <= 1'b0;
      st_ff <= nxt_st;
      if (st_ff == S_IDLE)
      begin
        if (diag_done)
        begin
          sense0 <= {2'b00, legal(diag_err)};
          cmd_done <= 1'b1;
        end
        else if (asg_valid)
        begin
          // substitute-track assignment checks
          if (asg_def == asg_sub)
            sense0 <= {2'b00, `FCER_E_SUB_SAME};
          else if (asg_sub_used)
            sense0 <= {2'b00, `FCER_E_SUB_USED};
          else if (asg_sub_noflag)
            sense0 <= {2'b00, `FCER_E_SUB_NOFLAG};
          else
            sense0 <= 8'h00;
          cmd_done <= 1'b1;
        end
        else if (cmd_valid)
        begin
          step_rate <= cmd_ctl[3:0];
          retry_off <= cmd_ctl[`FCER_CB_RETRY_OFF];
          fill_keep <= cmd_ctl[`FCER_CB_PATTERN];
          fill_byte <= `FCER_FILL;
          ilv_ff <= cmd_b4[4:0];
          is_fmt_ff <= (cmd_op == `FCER_OP_FORMAT);
          // round down to the track's first sector
          trk_lba_ff <= cmd_lba - (cmd_lba % sec_per_trk_lba);
          sec_ff <= {SW{1'b0}};
          if (code != `FCER_E_NONE)
          begin
            sense0 <= {2'b00, code};
            cmd_done <= 1'b1;
            st_ff <= S_WAIT;
          end
          else
          begin
            busy <= 1'b1;
            tab_start_ff <= 1'b1;
            st_ff <= S_TAB;
          end
        end
      end
      else if (st_ff != S_WAIT && st_ff != S_END && st_ff != S_TAB &&
               drv_op_done && drv_err != `FCER_E_NONE)
      begin
        // hard error: stop, report failing track
        sense0 <= {1'b1, 1'b0, legal(drv_err)};
        sense_lba <= trk_lba_ff;
        busy <= 1'b0;
        cmd_done <= 1'b1;
        st_ff <= S_IDLE;
      end
      else if (st_ff == S_RHDR && drv_op_done && !is_fmt_ff &&
               (hdr_bad || hdr_sec != tab_val))
      begin
        sense0 <= {2'b10, `FCER_E_FORMAT};
        sense_lba <= trk_lba_ff;
        busy <= 1'b0;
        cmd_done <= 1'b1;
        st_ff <= S_IDLE;
      end
      else if (st_ff == S_RHDR && drv_op_done && hdr_sub_flag && !sub_via_defect)
      begin
        sense0 <= {2'b10, `FCER_E_SUB_DIRECT};
        sense_lba <= trk_lba_ff;
        busy <= 1'b0;
        cmd_done <= 1'b1;
        st_ff <= S_IDLE;
      end
      else if (st_ff == S_END)
      begin
        sense0 <= {2'b10, `FCER_E_NONE};
        sense_lba <= trk_lba_ff + sec_per_trk_lba;
        busy <= 1'b0;
        cmd_done <= 1'b1;
      end
      else
      begin
        // issue drive operation on state entry or next sector
        if (nxt_st != st_ff || (drv_op_done && st_ff >= S_WHDR && st_ff <= S_WDATA))
        begin
          if (nxt_st != st_ff)
            sec_ff <= {SW{1'b0}};
          else
            sec_ff <= sec_ff + 1'b1;
          case (nxt_st)
            S_RECAL: drv_op <= OP_RECAL;
            S_SEEK: drv_op <= OP_SEEK;
            S_TIME: drv_op <= OP_TIME;
            S_WHDR: drv_op <= OP_WHDR;
            S_RHDR: drv_op <= OP_RHDR;
            S_WDATA: drv_op <= OP_WDATA;
            default: drv_op <= 3'd0;
          endcase
          drv_op_go <= (nxt_st != S_END && nxt_st != S_IDLE);
          drv_sec <= (nxt_st != st_ff) ? {SW{1'b0}} : sec_ff + 1'b1;
        end
        if (st_ff == S_TIME && drv_op_done)
          sec_slot_cycles <= slot_base / {{(32-SW){1'b0}}, nsec};
      end
    end
  end
endmodule // fcer_top
`default_nettype wire

// ### test/fcer_chk_asserts.sv
`default_nettype none
// watches sequencing and sense reporting
module fcer_chk (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_op,
  input wire logic [7:0] cmd_ctl,
  input wire logic [2:0] drv_op,
  input wire logic drv_op_go,
  input wire logic drv_op_done,
  input wire logic [5:0] drv_err,
  input wire logic [7:0] fill_byte,
  input wire logic fill_keep,
  input wire logic [3:0] step_rate,
  input wire logic retry_off,
  input wire logic busy,
  input wire logic cmd_done,
  input wire logic [7:0] sense0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fmt_ff;
  logic chk_ff;
  logic [7:0] ctl_ff;
  logic [3:0] go_ff;
  // latch the accepted command, count drive requests
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      fmt_ff <= 1'b0;
      chk_ff <= 1'b0;
      ctl_ff <= 8'h00;
      go_ff <= 4'h0;
    end
    else if (cmd_valid && !busy)
    begin
      fmt_ff <= cmd_op == 8'h04;
      chk_ff <= cmd_op == 8'h05;
      ctl_ff <= cmd_ctl;
      go_ff <= 4'h0;
    end
    else if (drv_op_go && go_ff != 4'hf)
      go_ff <= go_ff + 4'h1;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence s_fmt_go;
    fmt_ff && busy && drv_op_go;
  endsequence
  sequence s_quiet_done;
    !drv_op_go throughout (##[0:7] cmd_done);
  endsequence
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done longer than one cycle");
  a_go_busy: assert property (drv_op_go |-> busy)
    else $error("drive request while idle");
  a_recal_first: assert property (s_fmt_go and go_ff == 4'h0 |-> drv_op == 3'd1)
    else $error("format did not recalibrate first");
  a_seek_next: assert property (s_fmt_go and go_ff == 4'h1 |-> drv_op == 3'd2)
    else $error("format did not seek second");
  a_check_seek: assert property (chk_ff && drv_op_go && go_ff == 4'h0 |-> drv_op == 3'd2)
    else $error("check did not seek first");
  a_check_nodata: assert property (chk_ff && drv_op_go |-> drv_op inside {3'd2, 3'd5})
    else $error("check issued a forbidden drive op");
  a_fill_default: assert property (s_fmt_go and !ctl_ff[5] |-> fill_byte == 8'h6c && !fill_keep)
    else $error("fill pattern wrong");
  a_ctl_fields: assert property (s_fmt_go |-> step_rate == ctl_ff[3:0] && retry_off == ctl_ff[7])
    else $error("step rate or retry flag wrong");
  a_code_used: assert property (cmd_done |-> !sense0[6] && !(sense0[5:4] == 2'b00 && sense0[3:0] > 4'h8)
    && !(sense0[5:4] >= 2'b10 && sense0[3:0] > 4'h2)
    && !(sense0[5:0] inside {6'h05, 6'h07, 6'h13, 6'h16, 6'h17, 6'h1b}))
    else $error("unused code reported");
  a_stop_err: assert property (busy && drv_op_done && drv_err != 6'h00 |=> s_quiet_done)
    else $error("no prompt stop after drive error");
endmodule // fcer_chk
bind fcer_top fcer_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_ctl(cmd_ctl), .drv_op(drv_op), .drv_op_go(drv_op_go),
  .drv_op_done(drv_op_done), .drv_err(drv_err), .fill_byte(fill_byte), .fill_keep(fill_keep),
  .step_rate(step_rate), .retry_off(retry_off), .busy(busy), .cmd_done(cmd_done), .sense0(sense0));
`default_nettype wire

// ### test/fcer_drv_model.sv
`default_nettype none
// drive side: answers each request after a set delay
module fcer_drv_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [2:0] drv_op,
  input wire logic drv_op_go,
  input wire logic [4:0] drv_sec,
  input wire logic [3:0] dly,
  input wire logic [2:0] err_op,
  input wire logic [5:0] err_code,
  input wire logic mis_on,
  output logic drv_op_done,
  output logic [5:0] drv_err,
  output logic [31:0] rot_cycles,
  output logic [4:0] hdr_sec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_ff;
  logic [3:0] cnt_ff;
  logic [2:0] op_ff;
  logic [4:0] sec_ff;
  // one result per request, never one unasked
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      pend_ff <= 1'b0;
      cnt_ff <= 4'h0;
      op_ff <= 3'h0;
      sec_ff <= 5'h0;
      drv_op_done <= 1'b0;
    end
    else
    begin
      drv_op_done <= pend_ff && cnt_ff == 4'h0 && !drv_op_go;
      if (drv_op_go)
      begin
        pend_ff <= 1'b1;
        cnt_ff <= dly;
        op_ff <= drv_op;
        sec_ff <= drv_sec;
      end
      else if (cnt_ff != 4'h0)
        cnt_ff <= cnt_ff - 4'h1;
      else
        pend_ff <= 1'b0;
    end
  // results mean something only with done; junk otherwise
  assign drv_err = drv_op_done ? (op_ff == err_op ? err_code : 6'h00) : 6'h3f;
  assign rot_cycles = drv_op_done ? 32'd40000 : 32'hffff_ffff;
  assign hdr_sec = !drv_op_done ? ~sec_ff : (mis_on && sec_ff == 5'h2 ? 5'h3 : sec_ff);
endmodule // fcer_drv_model
`default_nettype wire

// ### test/fcer_tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, nrst = 0, cmd_valid = 0, diag_done = 0, asg_valid = 0, mis_on = 0;
  logic sub_on = 0, big_sec = 0;
  logic asg_sub_used = 0, asg_sub_noflag = 0, drv_op_done, drv_op_go, fill_keep, retry_off;
  logic busy, cmd_done;
  logic [7:0] cmd_op = 0, cmd_b4 = 0, cmd_ctl = 0, sense0, fill_byte, op;
  logic [20:0] cmd_lba = 0, asg_def = 0, asg_sub = 0, sense_lba, lba;
  logic [20:0] sec_per_trk_lba = 21'd4;
  logic [5:0] diag_err = 0, err_code = 0, drv_err;
  logic [2:0] drv_op, err_op = 0;
  logic [3:0] dly = 0, step_rate;
  logic [4:0] nsec = 5'd4, drv_sec, hdr_sec;
  logic [31:0] rot_cycles, sec_slot_cycles;
  int fail_count = 0, check_count = 0, cyc = 0;
  int codes[$] = '{'h30, 'h31, 'h32};
  fcer_top #(.MAX_LBA(21'h000fff)) uut (.clk_sys, .nrst, .cmd_valid, .cmd_op, .cmd_lba,
    .cmd_b4, .cmd_ctl, .sec512(big_sec), .nsec, .sec_per_trk_lba, .drv_op_done, .drv_err,
    .rot_cycles, .hdr_sec, .hdr_bad(1'b0), .hdr_sub_flag(sub_on), .sub_via_defect(1'b0),
    .diag_done, .diag_err, .asg_valid, .asg_def, .asg_sub, .asg_sub_used, .asg_sub_noflag,
    .drv_op, .drv_op_go, .drv_sec, .fill_byte, .fill_keep, .sec_slot_cycles, .step_rate,
    .retry_off, .busy, .cmd_done, .sense0, .sense_lba);
  fcer_drv_model u_drv (.clk_sys, .nrst, .drv_op, .drv_op_go, .drv_sec, .dly, .err_op,
    .err_code, .mis_on, .drv_op_done, .drv_err, .rot_cycles, .hdr_sec);
  // clock and hang limit
  initial
    forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // wait for the answer, then leave an idle cycle
  task automatic wt;
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 3000)
      fail_count++;
    @(negedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] o, input logic [20:0] a, input logic [7:0] b, input logic [7:0] c);
    cmd_op = o;
    cmd_lba = a;
    cmd_b4 = b;
    cmd_ctl = c;
    dly = 4'($urandom % 4);
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    wt;
  endtask
  task automatic asg(input logic [20:0] d, input logic [20:0] s, input logic u, input logic f);
    asg_def = d;
    asg_sub = s;
    asg_sub_used = u;
    asg_sub_noflag = f;
    asg_valid = 1'b1;
    @(negedge clk_sys);
    asg_valid = 1'b0;
    wt;
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // main sequence; expectations from track size 4 and rotation 40000
  initial
  begin
    void'($urandom(32'hb5d5));
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    chk(sense0, 0);
    chk(fill_byte, 'h6c);
    repeat (4)
    begin
      op = 8'($urandom) | 8'h40;
      cmd(op, 0, 1, 0);
      chk(sense0, 'h20);
    end
    foreach (codes[i])
    begin
      diag_err = 6'(codes[i]);
      diag_done = 1'b1;
      @(negedge clk_sys);
      diag_done = 1'b0;
      wt;
      chk(sense0, codes[i]);
    end
    asg(7, 7, 0, 0);
    chk(sense0, 'h1f);
    asg(7, 9, 1, 0);
    chk(sense0, 'h1d);
    asg(7, 9, 0, 1);
    chk(sense0, 'h1e);
    for (int k = 0; k < 2; k++)
    begin
      lba = 21'h104 + 21'($urandom % 4);
      cmd(8'h04, lba, 1, k ? 8'h20 : 8'h95);
      chk(sense0, 'h80);
      chk(sense_lba, 'h108);
      chk(sec_slot_cycles, k ? 10000 : (40000 - 30000) / 4);
      chk(fill_keep, k);
      chk({retry_off, step_rate}, k ? 0 : 'h15);
    end
    err_op = 3'd4;
    err_code = 6'h03;
    cmd(8'h04, 'h10a, 1, 0);
    chk(sense0, 'h83);
    chk(sense_lba, 'h108);
    err_op = 3'd0;
    cmd(8'h05, 'h109, 1, 0);
    chk({sense0, 3'h0, sense_lba}, 'h8000010c);
    mis_on = 1'b1;
    cmd(8'h05, 'h109, 1, 0);
    chk({sense0, 3'h0, sense_lba}, 'h9a000108);
    mis_on = 1'b0;
    cmd(8'h04, 'h100, 0, 0);
    chk(sense0[5:0], 'h22);
    cmd(8'h04, 'h1000, 1, 0);
    chk(sense0[5:0], 'h21);
    sub_on = 1'b1;
    cmd(8'h05, 'h109, 1, 0);
    chk({sense0, 3'h0, sense_lba}, 'h9c000108);
    sub_on = 1'b0;
    big_sec = 1'b1;
    cmd(8'h04, 'h100, 8'h11, 0);
    chk(sense0[5:0], 'h22);
    big_sec = 1'b0;
    finish_test;
  end
endmodule // tb
`default_nettype wire
